// ### inc/mfsr_consts.svh
// constants of the motor feedback select and ramp block
`ifndef MFSR_CONSTS_SVH
`define MFSR_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MFSR_CLK_NS       50
`define MFSR_MS_NS        1000000
`define MFSR_MS_CYC       (`MFSR_MS_NS / `MFSR_CLK_NS)
`define MFSR_RAW_MS       8'd100
`define MFSR_FAST_MS      8'd20

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MFSR_A_CTRL       8'h00
`define MFSR_A_SETPT      8'h04
`define MFSR_A_LEADER     8'h08
`define MFSR_A_RAWPER     8'h0C
`define MFSR_A_VRAMP      8'h10
`define MFSR_A_CLRAMP0    8'h14
`define MFSR_A_CLRAMP1    8'h18
`define MFSR_A_STATUS     8'h1C
`define MFSR_A_MASK       8'h20
`define MFSR_A_QPOS       8'h24
`define MFSR_A_QVEL       8'h28
`define MFSR_A_APOS       8'h2C
`define MFSR_A_AVEL       8'h30
`define MFSR_A_SPOS       8'h34
`define MFSR_A_SVEL       8'h38
`define MFSR_A_DRIVE      8'h3C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MFSR_CTRL_MODE_LSB 0
`define MFSR_CTRL_FB_LSB   4
`define MFSR_CTRL_INV_BIT  8
`define MFSR_CTRL_SLOT_BIT 12
`define MFSR_ST_RAW_BIT    0
`define MFSR_ST_FAST_BIT   1
`define MFSR_ST_UV_BIT     2
`define MFSR_ST_UVNOW_BIT  3
`define MFSR_ST_ARMED_BIT  4

// ----------------------------------------------------------------
// reset values and analog wrap thresholds
// ----------------------------------------------------------------
`define MFSR_RST_RAWPER   8'h64
`define MFSR_RST_MASK     3'h0
`define MFSR_ADC_LO       10'h100
`define MFSR_ADC_HI       10'h300
`define MFSR_ADC_SPAN     32'h0000_0400

`endif

// ### inc/mfsr_pkg.sv
// types of the motor feedback select and ramp block
package mfsr_pkg;

	typedef enum logic [1:0] {
		MFSR_DUTY   = 2'h0,
		MFSR_FOLLOW = 2'h1,
		MFSR_POSN   = 2'h2,
		MFSR_SPEED  = 2'h3
	} mfsr_mode_e;

	typedef enum logic [1:0] {
		MFSR_FB_QUAD = 2'h0,
		MFSR_FB_POT  = 2'h1,
		MFSR_FB_AENC = 2'h2,
		MFSR_FB_NONE = 2'h3
	} mfsr_fb_e;

	typedef logic [31:0] mfsr_word_t;
	typedef logic [11:0] mfsr_drive_t;

endpackage

// ### logic/mfsr_quad_decoder.sv
// four-edge quadrature decoder with a signed position count
`timescale 1ns/1ns
module mfsr_quad_decoder (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               chanA,
	input  wire logic               chanB,
	output mfsr_pkg::mfsr_word_t    position
);
	import mfsr_pkg::*;

	typedef struct packed {
		logic       prevA;
		logic       prevB;
		mfsr_word_t pos;
	} mfsr_qd_s;

	mfsr_qd_s state_r;
	mfsr_qd_s state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.prevA = chanA;
		state_nxt.prevB = chanB;
		// both edges at once is a lost step; holding beats guessing
		if ((chanA ^ state_r.prevA) != (chanB ^ state_r.prevB)) begin
			if (chanA ^ state_r.prevB) begin
				state_nxt.pos = state_r.pos + 32'h0000_0001;
			end else begin
				state_nxt.pos = state_r.pos - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign position = state_r.pos;

endmodule

// ### logic/motor_feedback_select_ramp.sv
// motor feedback select, raw sensor reports, drive ramp and neutral hold
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "mfsr_consts.svh"
module motor_feedback_select_ramp #(
	parameter int MS_CYC = `MFSR_MS_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  quadA,
	input  wire logic                  quadB,
	input  wire logic                  underVolt,
	input  wire logic [9:0]            adcSample,
	input  wire logic                  adcValid,
	input  wire mfsr_pkg::mfsr_drive_t loopOut,
	input  wire mfsr_pkg::mfsr_drive_t leaderThrottle,
	output mfsr_pkg::mfsr_word_t       fbPos,
	output mfsr_pkg::mfsr_word_t       fbVel,
	output logic                       rawReportStb,
	output logic                       fastReportStb,
	output mfsr_pkg::mfsr_drive_t      driveOut,
	output logic                       driveEnable,
	output logic                       irq
);
	import mfsr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        aS1;
		logic        aS2;
		logic        bS1;
		logic        bS2;
		logic        uvS1;
		logic        uvS2;
		logic [14:0] msCnt;
		logic [7:0]  rawCnt;
		logic [7:0]  fastCnt;
		mfsr_mode_e  mode;
		mfsr_fb_e    fbSel;
		logic        invert;
		logic        slot;
		mfsr_drive_t setpoint;
		logic [5:0]  leader;
		logic [7:0]  rawPer;
		mfsr_drive_t vramp;
		mfsr_drive_t clRamp0;
		mfsr_drive_t clRamp1;
		logic        armed;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic        irq;
		logic        adcSeen;
		logic [9:0]  adcPrev;
		mfsr_word_t  anaBase;
		mfsr_word_t  quadLast;
		mfsr_word_t  anaLast;
		mfsr_word_t  quadVel;
		mfsr_word_t  anaVel;
		mfsr_word_t  rawQPos;
		mfsr_word_t  rawQVel;
		mfsr_word_t  rawAPos;
		mfsr_word_t  rawAVel;
		mfsr_word_t  selPos;
		mfsr_word_t  selVel;
		mfsr_word_t  fbPos;
		mfsr_word_t  fbVel;
		logic        rawStb;
		logic        fastStb;
		mfsr_drive_t drive;
		logic        driveEn;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} mfsr_state_s;

	mfsr_state_s state_r;
	mfsr_state_s state_nxt;
	mfsr_word_t  quadPos;
	mfsr_word_t  anaPos;

	// ----------------------------------------------------------------
	// quadrature decoder
	// ----------------------------------------------------------------
	// quadrature decoded alongside analog
	mfsr_quad_decoder quadDec (
		.clk      (clk),
		.rst      (rst),
		.chanA    (state_r.aS2),
		.chanB    (state_r.bS2),
		.position (quadPos)
	);

	assign anaPos = state_r.anaBase + {22'h0, state_r.adcPrev};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        msTick;
		logic        setup;
		logic        wrDone;
		logic        rdDone;
		logic [7:0]  rawEff;
		logic [2:0]  events;
		mfsr_word_t  pickPos;
		mfsr_word_t  pickVel;
		mfsr_drive_t target;
		mfsr_drive_t limit;
		mfsr_drive_t clr;
		logic [12:0] diff;
		logic [12:0] mag;
		logic [31:0] rd;
		logic        hit;
		msTick  = 1'b0;
		setup   = 1'b0;
		wrDone  = 1'b0;
		rdDone  = 1'b0;
		rawEff  = 8'h0;
		events  = 3'h0;
		pickPos = '0;
		pickVel = '0;
		target  = '0;
		limit   = '0;
		clr     = '0;
		diff    = 13'h0;
		mag     = 13'h0;
		rd      = 32'h0;
		hit     = 1'b1;
		state_nxt = state_r;

		// pins pass two flops before use
		state_nxt.aS1  = quadA;
		state_nxt.aS2  = state_r.aS1;
		state_nxt.bS1  = quadB;
		state_nxt.bS2  = state_r.bS1;
		state_nxt.uvS1 = underVolt;
		state_nxt.uvS2 = state_r.uvS1;

		// millisecond enable
		if (state_r.msCnt == 15'(MS_CYC - 1)) begin
			msTick = 1'b1;
			state_nxt.msCnt = 15'h0;
		end else begin
			state_nxt.msCnt = state_r.msCnt + 15'h1;
		end

		// analog sample tracking
		if (adcValid) begin
			state_nxt.adcSeen = 1'b1;
			state_nxt.adcPrev = adcSample;
			if (state_r.adcSeen) begin
				if (state_r.adcPrev >= `MFSR_ADC_HI && adcSample < `MFSR_ADC_LO) begin
					state_nxt.anaBase = state_r.anaBase + `MFSR_ADC_SPAN;
				end else if (state_r.adcPrev < `MFSR_ADC_LO && adcSample >= `MFSR_ADC_HI) begin
					state_nxt.anaBase = state_r.anaBase - `MFSR_ADC_SPAN;
				end
			end
		end

		// velocity is change per millisecond
		if (msTick) begin
			state_nxt.quadVel  = quadPos - state_r.quadLast;
			state_nxt.quadLast = quadPos;
			state_nxt.anaVel   = anaPos - state_r.anaLast;
			state_nxt.anaLast  = anaPos;
		end

		// sensor mux to the closed-loop feedback outputs
		case (state_r.fbSel)
			MFSR_FB_QUAD: begin
				pickPos = quadPos;
				pickVel = state_r.quadVel;
			end
			MFSR_FB_POT: begin
				// absolute analog is the bare sample
				pickPos = {22'h0, state_r.adcPrev};
				pickVel = state_r.anaVel;
			end
			MFSR_FB_AENC: begin
				pickPos = anaPos;
				pickVel = state_r.anaVel;
			end
			default: begin
				pickPos = '0;
				pickVel = '0;
			end
		endcase
		if (state_r.invert) begin
			pickPos = 32'h0 - pickPos;
			pickVel = 32'h0 - pickVel;
		end
		state_nxt.fbPos = pickPos;
		state_nxt.fbVel = pickVel;

		rawEff = (state_r.rawPer == 8'h0 || state_r.rawPer > `MFSR_RAW_MS) ? `MFSR_RAW_MS : state_r.rawPer;
		state_nxt.rawStb  = 1'b0;
		state_nxt.fastStb = 1'b0;
		if (msTick) begin
			if (state_r.rawCnt >= rawEff - 8'h1) begin
				state_nxt.rawCnt  = 8'h0;
				state_nxt.rawStb  = 1'b1;
				state_nxt.rawQPos = quadPos;
				state_nxt.rawQVel = state_r.quadVel;
				state_nxt.rawAPos = anaPos;
				state_nxt.rawAVel = state_r.anaVel;
				events[`MFSR_ST_RAW_BIT] = 1'b1;
			end else begin
				state_nxt.rawCnt = state_r.rawCnt + 8'h1;
			end
			if (state_r.fastCnt >= `MFSR_FAST_MS - 8'h1) begin
				state_nxt.fastCnt = 8'h0;
				state_nxt.fastStb = 1'b1;
				state_nxt.selPos  = state_r.fbPos;
				state_nxt.selVel  = state_r.fbVel;
				events[`MFSR_ST_FAST_BIT] = 1'b1;
			end else begin
				state_nxt.fastCnt = state_r.fastCnt + 8'h1;
			end
		end

		events[`MFSR_ST_UV_BIT] = state_r.uvS2;

		// ----------------------------------------------------------------
		// apb slave, zero wait states
		// ----------------------------------------------------------------
		setup  = psel & ~penable;
		wrDone = psel & penable & state_r.pready & pwrite & ~state_r.pslverr;
		rdDone = psel & penable & state_r.pready & ~pwrite;
		case (paddr)
			`MFSR_A_CTRL: begin
				rd[`MFSR_CTRL_MODE_LSB +: 2] = state_r.mode;
				rd[`MFSR_CTRL_FB_LSB +: 2]   = state_r.fbSel;
				rd[`MFSR_CTRL_INV_BIT]       = state_r.invert;
				rd[`MFSR_CTRL_SLOT_BIT]      = state_r.slot;
			end
			`MFSR_A_SETPT:   rd = {20'h0, state_r.setpoint};
			`MFSR_A_LEADER:  rd = {26'h0, state_r.leader};
			`MFSR_A_RAWPER:  rd = {24'h0, state_r.rawPer};
			`MFSR_A_VRAMP:   rd = {20'h0, state_r.vramp};
			`MFSR_A_CLRAMP0: rd = {20'h0, state_r.clRamp0};
			`MFSR_A_CLRAMP1: rd = {20'h0, state_r.clRamp1};
			`MFSR_A_STATUS: begin
				rd[2:0]                = state_r.status;
				rd[`MFSR_ST_UVNOW_BIT] = state_r.uvS2;
				rd[`MFSR_ST_ARMED_BIT] = state_r.armed;
			end
			`MFSR_A_MASK:    rd = {29'h0, state_r.mask};
			`MFSR_A_QPOS:    rd = state_r.rawQPos;
			`MFSR_A_QVEL:    rd = state_r.rawQVel;
			`MFSR_A_APOS:    rd = state_r.rawAPos;
			`MFSR_A_AVEL:    rd = state_r.rawAVel;
			`MFSR_A_SPOS:    rd = state_r.selPos;
			`MFSR_A_SVEL:    rd = state_r.selVel;
			`MFSR_A_DRIVE:   rd = {19'h0, state_r.driveEn, state_r.drive};
			default:         hit = 1'b0;
		endcase
		state_nxt.pready  = setup;
		state_nxt.pslverr = setup & ~hit;
		if (setup) begin
			state_nxt.prdata = (pwrite || !hit) ? 32'h0 : rd;
		end

		if (wrDone) begin
			case (paddr)
				`MFSR_A_CTRL: begin
					state_nxt.mode   = mfsr_mode_e'(pwdata[`MFSR_CTRL_MODE_LSB +: 2]);
					state_nxt.fbSel  = mfsr_fb_e'(pwdata[`MFSR_CTRL_FB_LSB +: 2]);
					state_nxt.invert = pwdata[`MFSR_CTRL_INV_BIT];
					state_nxt.slot   = pwdata[`MFSR_CTRL_SLOT_BIT];
					// mode change drops to no drive
					if (pwdata[`MFSR_CTRL_MODE_LSB +: 2] != state_r.mode) begin
						state_nxt.armed = 1'b0;
					end
				end
				`MFSR_A_SETPT: begin
					state_nxt.setpoint = pwdata[11:0];
					state_nxt.armed = 1'b1;
				end
				`MFSR_A_LEADER: begin
					state_nxt.leader = pwdata[5:0];
					state_nxt.armed  = 1'b1;
				end
				`MFSR_A_RAWPER:  state_nxt.rawPer  = pwdata[7:0];
				`MFSR_A_VRAMP:   state_nxt.vramp   = pwdata[11:0];
				`MFSR_A_CLRAMP0: state_nxt.clRamp0 = pwdata[11:0];
				`MFSR_A_CLRAMP1: state_nxt.clRamp1 = pwdata[11:0];
				`MFSR_A_MASK:    state_nxt.mask    = pwdata[2:0];
				default: begin
				end
			endcase
		end

		// read clears; a same-cycle event survives the clear
		if (rdDone && paddr == `MFSR_A_STATUS) begin
			state_nxt.status = 3'h0;
		end
		state_nxt.status = state_nxt.status | events;
		state_nxt.irq = |(state_nxt.status & state_nxt.mask);

		// ----------------------------------------------------------------
		// drive shaping
		// ----------------------------------------------------------------
		case (state_r.mode)
			MFSR_DUTY:   target = state_r.setpoint;
			MFSR_FOLLOW: target = leaderThrottle;
			MFSR_POSN:   target = loopOut;
			MFSR_SPEED:  target = loopOut;
			default:     target = '0;
		endcase
		limit = state_r.vramp;
		clr = state_r.slot ? state_r.clRamp1 : state_r.clRamp0;
		if ((state_r.mode == MFSR_POSN || state_r.mode == MFSR_SPEED) && clr != 12'h0) begin
			if (limit == 12'h0 || clr < limit) begin
				limit = clr;
			end
		end
		state_nxt.driveEn = state_nxt.armed;
		if (!state_nxt.armed) begin
			state_nxt.drive = '0;
		end else if (msTick) begin
			diff = {target[11], target} - {state_r.drive[11], state_r.drive};
			mag = diff[12] ? 13'h0 - diff : diff;
			// zero limit means unlimited slew
			if (limit == 12'h0 || mag <= {1'b0, limit}) begin
				state_nxt.drive = target;
			end else if (diff[12]) begin
				state_nxt.drive = state_r.drive - limit;
			end else begin
				state_nxt.drive = state_r.drive + limit;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r        <= '0;
			state_r.mode   <= MFSR_DUTY;
			state_r.fbSel  <= MFSR_FB_QUAD;
			state_r.rawPer <= `MFSR_RST_RAWPER;
			state_r.mask   <= `MFSR_RST_MASK;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign prdata        = state_r.prdata;
	assign pready        = state_r.pready;
	assign pslverr       = state_r.pslverr;
	assign fbPos         = state_r.fbPos;
	assign fbVel         = state_r.fbVel;
	assign rawReportStb  = state_r.rawStb;
	assign fastReportStb = state_r.fastStb;
	assign driveOut      = state_r.drive;
	assign driveEnable   = state_r.driveEn;
	assign irq           = state_r.irq;

endmodule

// ### verif/mfsr_monitor.sv
// concurrent checks on the ports of the feedback select and ramp block
`timescale 1ns/1ns
`include "mfsr_consts.svh"
module mfsr_monitor #(
	parameter int MS_CYC = 20
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [31:0]           prdata,
	input  wire logic                  pready,
	input  wire logic                  pslverr,
	input  wire logic                  underVolt,
	input  wire logic                  rawReportStb,
	input  wire logic                  fastReportStb,
	input  wire mfsr_pkg::mfsr_drive_t driveOut,
	input  wire logic                  driveEnable,
	input  wire logic                  irq
);
	import mfsr_pkg::*;
	logic [1:0]  mode_r;
	logic [2:0]  mask_r;
	logic [31:0] fastCnt_r;
	logic [31:0] rawCnt_r;
	logic        fastSeen_r;
	wire         wrDone = psel && penable && pready && pwrite;

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_r <= 2'h0;
			mask_r <= 3'h0;
			fastCnt_r <= 32'h0;
			rawCnt_r <= 32'h0;
			fastSeen_r <= 1'b0;
		end else begin
			if (wrDone && paddr == `MFSR_A_CTRL)
				mode_r <= pwdata[1:0];
			if (wrDone && paddr == `MFSR_A_MASK)
				mask_r <= pwdata[2:0];
			fastCnt_r <= fastReportStb ? 32'h0 : fastCnt_r + 32'h1;
			rawCnt_r <= rawReportStb ? 32'h0 : rawCnt_r + 32'h1;
			fastSeen_r <= fastSeen_r | fastReportStb;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence setupSeq;
		psel && !penable;
	endsequence
	sequence uvHeld;
		(mask_r[2] && underVolt)[*3];
	endsequence

	a_pready_access: assert property (setupSeq |=> pready)
		else $error("no pready after setup");
	a_unmapped_err: assert property (setupSeq ##0 paddr > `MFSR_A_DRIVE |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_fast_period: assert property (fastReportStb && fastSeen_r |-> fastCnt_r == 20 * MS_CYC - 1)
		else $error("fast report period wrong");
	a_raw_bound: assert property (rawCnt_r <= 100 * MS_CYC + 2)
		else $error("raw report overdue");
	a_strobe_pulse: assert property (rawReportStb |=> !rawReportStb)
		else $error("raw strobe longer than a cycle");
	a_idle_zero: assert property (!driveEnable |-> driveOut == 12'h000)
		else $error("drive while disarmed");
	a_mode_disarm: assert property (wrDone && paddr == `MFSR_A_CTRL && pwdata[1:0] != mode_r |=> !driveEnable)
		else $error("mode change left drive armed");
	a_setpt_arms: assert property (wrDone && (paddr == `MFSR_A_SETPT || paddr == `MFSR_A_LEADER) |=> driveEnable)
		else $error("set-point did not arm");
	a_drive_hold: assert property ($changed(driveOut) && driveEnable |=> ($stable(driveOut) || !driveEnable)[*8])
		else $error("drive stepped between ticks");
	a_uv_irq: assert property (uvHeld |-> ##[1:4] irq)
		else $error("undervolt gave no interrupt");
	a_irq_masked: assert property (mask_r == 3'h0 |-> !irq)
		else $error("interrupt while all masked");
endmodule

// ### verif/mfsr_sensor_model.sv
// sensor side stand-in: quadrature encoder pins and converter samples
`timescale 1ns/1ns
module mfsr_sensor_model (
	input  wire logic  clk,
	output logic       quadA,
	output logic       quadB,
	output logic [9:0] adcSample,
	output logic       adcValid
);
	initial begin
		quadA = 1'b0;
		quadB = 1'b0;
		adcSample = 10'h000;
		adcValid = 1'b0;
	end

	// forward gray steps, held long enough for the pin synchroniser
	task automatic quadStep(input int n);
		repeat (n) begin
			@(posedge clk);
			{quadA, quadB} <= {~quadB, quadA};
			repeat (4) @(posedge clk);
		end
	endtask

	// sample lines show junk once the strobe is gone
	task automatic adcPut(input logic [9:0] v);
		@(posedge clk);
		adcSample <= v;
		adcValid <= 1'b1;
		@(posedge clk);
		adcValid <= 1'b0;
		adcSample <= ~v;
	endtask
endmodule

// ### verif/testbench.sv
// self-checking bench for the feedback select and ramp block
`timescale 1ns/1ns
`include "mfsr_consts.svh"
module testbench;
	import mfsr_pkg::*;
	localparam int MS = 20;
	logic        clk, rst, psel, penable, pwrite, underVolt;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, e, rawReportStb, fastReportStb, driveEnable, irq;
	logic        quadA, quadB, adcValid;
	logic [9:0]  adcSample;
	mfsr_drive_t loopOut, leaderThrottle, driveOut;
	mfsr_word_t  fbPos, fbVel;
	int          fails, checked, cycles, n;
	logic [9:0]  adcSeq [6] = '{10'h3FF, 10'h000, 10'h3FF, 10'h100, 10'h000, 10'h3FF};
	logic [31:0] adcExp [6] = '{32'h3FF, 32'h400, 32'h3FF, 32'h100, 32'h0, 32'hFFFF_FFFF};

	motor_feedback_select_ramp #(.MS_CYC(MS)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.quadA(quadA), .quadB(quadB), .underVolt(underVolt), .adcSample(adcSample), .adcValid(adcValid),
		.loopOut(loopOut), .leaderThrottle(leaderThrottle), .fbPos(fbPos), .fbVel(fbVel),
		.rawReportStb(rawReportStb), .fastReportStb(fastReportStb), .driveOut(driveOut),
		.driveEnable(driveEnable), .irq(irq));
	mfsr_sensor_model sens (.clk(clk), .quadA(quadA), .quadB(quadB), .adcSample(adcSample), .adcValid(adcValid));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// request held until pready is sampled high at a rising edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			fails++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(exp, r & msk);
	endtask

	task automatic waitStb(input logic fast);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((fast ? fastReportStb : rawReportStb) !== 1'b1 && n < 3000);
	endtask

	// every step of the drive must stay within the ramp limit
	task automatic watchDrive(input int lim, input int cyc, input logic [11:0] fin);
		logic [11:0] prev;
		int d, bad;
		prev = driveOut;
		bad = 0;
		repeat (cyc) begin
			@(negedge clk);
			d = $signed(driveOut) - $signed(prev);
			if (d > lim || d < -lim)
				bad++;
			prev = driveOut;
		end
		chk(32'h0, bad);
		chk({20'h0, fin}, {20'h0, driveOut});
	endtask

	task automatic pulseUv();
		@(posedge clk);
		underVolt <= 1'b1;
		repeat (8) @(posedge clk);
		underVolt <= 1'b0;
		repeat (6) @(negedge clk);
	endtask

	task automatic wrap_up();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, underVolt} = {1'b1, 44'h0};
		{fails, checked, cycles} = 0;
		loopOut = 12'h005;
		leaderThrottle = 12'hFFC;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdChk(`MFSR_A_RAWPER, 32'hFF, 32'h64);
		rdChk(`MFSR_A_MASK, 32'h7, 32'h0);
		xfer(8'hFC, 1'b0, 32'h0);
		chk(32'h0, r);
		chk(32'h1, {31'h0, e});
		chk(32'h0, {31'h0, driveEnable});
		sens.quadStep(8);
		sens.adcPut(10'h123);
		waitStb(1'b0);
		waitStb(1'b0);
		chk(100 * MS, n);
		rdChk(`MFSR_A_QPOS, 32'hFFFF_FFFF, 32'h8);
		rdChk(`MFSR_A_APOS, 32'hFFFF_FFFF, 32'h123);
		xfer(`MFSR_A_RAWPER, 1'b1, 32'h5);
		waitStb(1'b0);
		waitStb(1'b0);
		chk(5 * MS, n);
		waitStb(1'b1);
		waitStb(1'b1);
		chk(20 * MS, n);
		rdChk(`MFSR_A_SPOS, 32'hFFFF_FFFF, 32'h8);
		xfer(`MFSR_A_CTRL, 1'b1, 32'h100);
		repeat (3) @(negedge clk);
		chk(32'hFFFF_FFF8, fbPos);
		sens.quadStep(12);
		@(negedge clk);
		chk(32'hFFFF_FFFC, fbVel);
		xfer(`MFSR_A_CTRL, 1'b1, 32'h10);
		repeat (3) @(negedge clk);
		chk(32'h123, fbPos);
		xfer(`MFSR_A_CTRL, 1'b1, 32'h20);
		foreach (adcSeq[i]) begin
			sens.adcPut(adcSeq[i]);
			repeat (3) @(negedge clk);
			chk(adcExp[i], fbPos);
		end
		xfer(`MFSR_A_CTRL, 1'b1, 32'h10);
		repeat (3) @(negedge clk);
		chk(32'h3FF, fbPos);
		xfer(`MFSR_A_CTRL, 1'b1, 32'h30);
		repeat (3) @(negedge clk);
		chk(32'h0, fbPos);
		xfer(`MFSR_A_VRAMP, 1'b1, 32'h3);
		xfer(`MFSR_A_SETPT, 1'b1, 32'hA);
		@(negedge clk);
		chk(32'h1, {31'h0, driveEnable});
		watchDrive(3, 120, 12'h00A);
		xfer(`MFSR_A_CTRL, 1'b1, 32'h3);
		@(negedge clk);
		chk(32'h0, {19'h0, driveEnable, driveOut});
		xfer(`MFSR_A_CLRAMP0, 1'b1, 32'h1);
		xfer(`MFSR_A_SETPT, 1'b1, 32'h0);
		watchDrive(1, 160, 12'h005);
		rdChk(`MFSR_A_DRIVE, 32'h1FFF, 32'h1005);
		@(posedge clk);
		loopOut <= 12'hFF0;
		xfer(`MFSR_A_CTRL, 1'b1, 32'h1003);
		watchDrive(3, 200, 12'hFF0);
		xfer(`MFSR_A_CLRAMP1, 1'b1, 32'h2);
		xfer(`MFSR_A_CTRL, 1'b1, 32'h1002);
		xfer(`MFSR_A_SETPT, 1'b1, 32'h0);
		watchDrive(2, 200, 12'hFF0);
		xfer(`MFSR_A_CTRL, 1'b1, 32'h1);
		xfer(`MFSR_A_LEADER, 1'b1, 32'h5);
		watchDrive(3, 100, 12'hFFC);
		pulseUv();
		chk(32'h0, {31'h0, irq});
		xfer(`MFSR_A_MASK, 1'b1, 32'h4);
		repeat (2) @(negedge clk);
		chk(32'h1, {31'h0, irq});
		rdChk(`MFSR_A_STATUS, 32'h4, 32'h4);
		repeat (2) @(negedge clk);
		chk(32'h0, {31'h0, irq});
		pulseUv();
		rdChk(`MFSR_A_STATUS, 32'h4, 32'h4);
		rdChk(`MFSR_A_STATUS, 32'h4, 32'h0);
		wrap_up();
	end
endmodule

bind motor_feedback_select_ramp mfsr_monitor #(.MS_CYC(MS_CYC)) mon (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .underVolt(underVolt), .rawReportStb(rawReportStb), .fastReportStb(fastReportStb),
	.driveOut(driveOut), .driveEnable(driveEnable), .irq(irq));
